// ### hdl/swu_map.vh
// register map, field positions, reset values and timing counts for the wake sequencer
`ifndef SWU_MAP_VH
`define SWU_MAP_VH

// ==========================================================
// register byte offsets
`define SWU_CTRL_OFS 5'h00
`define SWU_MASK_OFS 5'h04
`define SWU_UNLOCK_OFS 5'h08
`define SWU_RELEASE_OFS 5'h0c
`define SWU_STATUS_OFS 5'h10

// ==========================================================
// control register fields
`define SWU_CTRL_SUSP_EN 0
`define SWU_CTRL_ACTIVE_DRIVE 1
`define SWU_CTRL_REINIT_EN 2
`define SWU_CTRL_CLK_SEL 3
`define SWU_CTRL_MULTIPIN_EN 4
`define SWU_CTRL_CRC_USE 5
`define SWU_CTRL_WIDTH 6
`define SWU_CTRL_RESET 6'h00

// ==========================================================
// status register fields
`define SWU_STAT_STATE_LSB 0
`define SWU_STAT_PIN 3
`define SWU_STAT_UNLOCK 4
`define SWU_STAT_RELEASE 5
`define SWU_STAT_CRC_ERR 6
`define SWU_STAT_RESTART 7

// ==========================================================
// reset values and count limits
`define SWU_MASK_RESET 8'h00
`define SWU_CNT_WIDTH 11
`define SWU_UNLOCK_RESET 11'h005
`define SWU_RELEASE_RESET 11'h004
`define SWU_CNT_MIN 11'h001
`define SWU_CNT_MAX 11'h400

// ==========================================================
// timing
`define SWU_SYS_CLK_MHZ 100
`define SWU_OSC_MHZ 50
`define SWU_OSC_DIV (`SWU_SYS_CLK_MHZ / `SWU_OSC_MHZ)
// last divider count at the two-bit divider width, one tick per two system clocks
`define SWU_OSC_DIV_LAST 2'h1
`define SWU_REINIT_CYCLES 4'h4

// ==========================================================
// axi responses
`define SWU_RESP_OKAY 2'b00
`define SWU_RESP_SLVERR 2'b10

`endif

// ### hdl/swu_release_counter.v
// one wake-up release counter: counts wake clock ticks up to a programmed target
`default_nettype none

module swu_release_counter (
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire run,
  input wire tick,
  input wire [10:0] target,
  output reg done
);

  // ==========================================================
  // tick counter
  reg [10:0] count_reg;

  // clear wins; counting only while run, stops once done
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 11'h000;
      done <= 1'b0;
    end else if (clear) begin
      count_reg <= 11'h000;
      done <= 1'b0;
    end else if (run && tick && !done) begin
      count_reg <= count_reg + 11'h001;
      // done the same edge the target count is reached
      if (count_reg + 11'h001 >= target) begin
        done <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/swu_sequencer.v
// suspend / wake-up sequencer with axi4-lite control registers
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "swu_map.vh"
`default_nettype none

module swu_sequencer (
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pins from the outside world
  input wire suspend_request_pin,
  input wire wake_status_pin_in,
  input wire [7:0] wake_request_pins,
  input wire user_clock_pin,
  input wire supply_core_ok,
  input wire supply_aux_ok,
  input wire crc_error_event,
  // wake status pin drive
  output reg wake_status_pin_out,
  output reg wake_status_pin_oe,
  // controls to the rest of the device
  output reg global_reinit_pulse,
  output reg write_unlock,
  output reg output_release,
  output reg crc_check_enable,
  output reg config_restart
);

  // ==========================================================
  // states
  localparam [2:0] ST_ACTIVE = 3'h0;
  localparam [2:0] ST_SUSPEND = 3'h1;
  localparam [2:0] ST_REINIT = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_RESTART = 3'h4;

  // ==========================================================
  // software registers
  reg [5:0] ctrl_reg; // mode bits
  reg [7:0] mask_reg; // wake request mask
  reg [10:0] unlock_cnt_reg; // write unlock count
  reg [10:0] release_cnt_reg; // output release count

  // ==========================================================
  // sequencer state
  reg [2:0] state_reg;
  reg [3:0] reinit_cnt_reg; // global reinit pulse length
  reg crc_err_reg; // sticky background crc error
  wire unlock_done; // write unlock counter reached target
  wire release_done; // output release counter reached target

  // ==========================================================
  // two-flop synchronisers for every pin input
  reg [13:0] sync1_reg; // first stage, read only by sync2
  reg [13:0] sync2_reg; // second stage, safe to use
  reg user_clk_last_reg; // previous synced user clock for edge detection

  // first flop looks only at the pins, second only at the first
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
      user_clk_last_reg <= 1'b0;
    end else begin
      sync1_reg <= {crc_error_event, supply_aux_ok, supply_core_ok, user_clock_pin,
                    wake_request_pins, wake_status_pin_in, suspend_request_pin};
      sync2_reg <= sync1_reg;
      user_clk_last_reg <= sync2_reg[10];
    end
  end

  wire susp_req_s = sync2_reg[0];
  wire wake_pin_s = sync2_reg[1];
  wire [7:0] wake_req_s = sync2_reg[9:2];
  wire user_clk_s = sync2_reg[10];
  wire supply_ok_s = sync2_reg[11] & sync2_reg[12];
  wire crc_evt_s = sync2_reg[13];

  // ==========================================================
  // wake timing clock as a tick enable
  reg [1:0] osc_div_reg; // stands in for the internal oscillator

  // divide the system clock down to the oscillator rate
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_div_reg <= 2'h0;
    end else if (osc_div_reg == `SWU_OSC_DIV_LAST) begin
      osc_div_reg <= 2'h0;
    end else begin
      osc_div_reg <= osc_div_reg + 2'h1;
    end
  end

  // user clock edges are the only path that lets peers count in lockstep
  wire user_tick = user_clk_s & ~user_clk_last_reg;
  wire osc_tick = (osc_div_reg == 2'h0);
  wire wake_tick = ctrl_reg[`SWU_CTRL_CLK_SEL] ? osc_tick : user_tick;

  // ==========================================================
  // wake condition
  // masked wake pins only count when multi-pin wake is enabled
  wire multipin_hit = ctrl_reg[`SWU_CTRL_MULTIPIN_EN] & (|(wake_req_s & mask_reg));
  wire wake_cond = ~susp_req_s | multipin_hit;

  // ==========================================================
  // release counters
  // both cleared on entry to suspend and during reinit; run only once pin is high
  wire cnt_clear = (state_reg != ST_WAKE);
  wire cnt_run = (state_reg == ST_WAKE) & wake_pin_s;

  swu_release_counter u_unlock_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(cnt_clear),
    .run(cnt_run),
    .tick(wake_tick),
    .target(unlock_cnt_reg),
    .done(unlock_done)
  );

  swu_release_counter u_release_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(cnt_clear),
    .run(cnt_run),
    .tick(wake_tick),
    .target(release_cnt_reg),
    .done(release_done)
  );

  // ==========================================================
  // sequencer state machine
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_ACTIVE;
      reinit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        // normal operation; suspend pin ignored unless feature enabled
        ST_ACTIVE: begin
          if (ctrl_reg[`SWU_CTRL_SUSP_EN] && susp_req_s) begin
            state_reg <= ST_SUSPEND;
          end
        end
        // suspended; supply loss restarts, crc error blocks the wake path
        ST_SUSPEND: begin
          if (!supply_ok_s) begin
            state_reg <= ST_RESTART;
          end else if (wake_cond && !crc_err_reg) begin
            if (ctrl_reg[`SWU_CTRL_REINIT_EN]) begin
              state_reg <= ST_REINIT;
              reinit_cnt_reg <= `SWU_REINIT_CYCLES;
            end else begin
              state_reg <= ST_WAKE;
            end
          end
        end
        // reinit pulse, pin still low and counters held clear
        ST_REINIT: begin
          if (!supply_ok_s) begin
            state_reg <= ST_RESTART;
          end else if (reinit_cnt_reg == 4'h1) begin
            state_reg <= ST_WAKE;
            reinit_cnt_reg <= 4'h0;
          end else begin
            reinit_cnt_reg <= reinit_cnt_reg - 4'h1;
          end
        end
        // pin released; wait until both counters are done
        ST_WAKE: begin
          if (!supply_ok_s) begin
            state_reg <= ST_RESTART;
          end else if (unlock_done && release_done) begin
            state_reg <= ST_ACTIVE;
          end
        end
        // held until the supplies recover; stands for a fresh configuration
        ST_RESTART: begin
          if (supply_ok_s) begin
            state_reg <= ST_ACTIVE;
          end
        end
        default: begin
          state_reg <= ST_ACTIVE;
        end
      endcase
    end
  end

  // ==========================================================
  // sticky crc error: only a restart or reset clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_err_reg <= 1'b0;
    end else if (crc_check_enable && crc_evt_s) begin
      crc_err_reg <= 1'b1;
    end else if (state_reg == ST_RESTART) begin
      crc_err_reg <= 1'b0;
    end
  end

  // ==========================================================
  // registered outputs toward the pin and the device
  wire in_suspend = (state_reg == ST_SUSPEND) | (state_reg == ST_REINIT) | (state_reg == ST_RESTART);

  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_status_pin_out <= 1'b1;
      wake_status_pin_oe <= 1'b0;
      global_reinit_pulse <= 1'b0;
      write_unlock <= 1'b1;
      output_release <= 1'b1;
      crc_check_enable <= 1'b0;
      config_restart <= 1'b0;
    end else begin
      // 0 while suspended, 1 once released
      wake_status_pin_out <= ~in_suspend;
      // open drain by default: drive only the low level
      wake_status_pin_oe <= in_suspend | ctrl_reg[`SWU_CTRL_ACTIVE_DRIVE];
      global_reinit_pulse <= (state_reg == ST_REINIT);
      write_unlock <= (state_reg == ST_ACTIVE) | ((state_reg == ST_WAKE) & unlock_done);
      output_release <= (state_reg == ST_ACTIVE) | ((state_reg == ST_WAKE) & release_done);
      crc_check_enable <= ctrl_reg[`SWU_CTRL_CRC_USE] & (state_reg == ST_ACTIVE);
      config_restart <= (state_reg == ST_RESTART);
    end
  end

  // ==========================================================
  // count clamp into the legal 1..1024 range
  function [10:0] clamp_count;
    input [15:0] value;
    begin
      if (value == 16'h0000) begin
        clamp_count = `SWU_CNT_MIN;
      end else if (value > {5'h00, `SWU_CNT_MAX}) begin
        clamp_count = `SWU_CNT_MAX;
      end else begin
        clamp_count = value[10:0];
      end
    end
  endfunction

  // ==========================================================
  // axi4-lite write channel
  reg aw_got_reg; // address held
  reg w_got_reg; // data held
  reg [4:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire [15:0] cnt_unlock_merged = {wstrb_reg[1] ? wdata_reg[15:8] : {5'h00, unlock_cnt_reg[10:8]},
                                   wstrb_reg[0] ? wdata_reg[7:0] : unlock_cnt_reg[7:0]};
  wire [15:0] cnt_release_merged = {wstrb_reg[1] ? wdata_reg[15:8] : {5'h00, release_cnt_reg[10:8]},
                                    wstrb_reg[0] ? wdata_reg[7:0] : release_cnt_reg[7:0]};

  // address and data taken in either order; response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWU_RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      ctrl_reg <= `SWU_CTRL_RESET;
      mask_reg <= `SWU_MASK_RESET;
      unlock_cnt_reg <= `SWU_UNLOCK_RESET;
      release_cnt_reg <= `SWU_RELEASE_RESET;
    end else begin
      // address channel
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // data channel
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // perform the write once both halves are held
      if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SWU_RESP_OKAY;
        case (awaddr_reg)
          `SWU_CTRL_OFS: begin
            if (wstrb_reg[0]) begin
              ctrl_reg <= wdata_reg[5:0];
            end
          end
          `SWU_MASK_OFS: begin
            if (wstrb_reg[0]) begin
              mask_reg <= wdata_reg[7:0];
            end
          end
          // counts are clamped so a zero or oversize write still behaves
          `SWU_UNLOCK_OFS: begin
            unlock_cnt_reg <= clamp_count(cnt_unlock_merged);
          end
          `SWU_RELEASE_OFS: begin
            release_cnt_reg <= clamp_count(cnt_release_merged);
          end
          // status is read only; writes there are accepted and dropped
          `SWU_STATUS_OFS: begin
            s_axi_bresp <= `SWU_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SWU_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SWU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SWU_RESP_OKAY;
      case (s_axi_araddr)
        `SWU_CTRL_OFS: begin
          s_axi_rdata <= {26'h0000000, ctrl_reg};
        end
        `SWU_MASK_OFS: begin
          s_axi_rdata <= {24'h000000, mask_reg};
        end
        `SWU_UNLOCK_OFS: begin
          s_axi_rdata <= {21'h000000, unlock_cnt_reg};
        end
        `SWU_RELEASE_OFS: begin
          s_axi_rdata <= {21'h000000, release_cnt_reg};
        end
        // live view of the sequencer
        `SWU_STATUS_OFS: begin
          s_axi_rdata <= {24'h000000, config_restart, crc_err_reg, output_release,
                          write_unlock, wake_pin_s, state_reg};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SWU_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### sim/swu_props.sv
// concurrent checks on the wake sequencer ports
`default_nettype none
module swu_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic wake_status_pin_in,
  input wire logic supply_core_ok,
  input wire logic supply_aux_ok,
  input wire logic wake_status_pin_out,
  input wire logic global_reinit_pulse,
  input wire logic write_unlock,
  input wire logic output_release,
  input wire logic crc_check_enable,
  input wire logic config_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // sequences
  // six samples low outlast the pin synchroniser, so counters must be frozen
  sequence pin_held_low;
    (!wake_status_pin_in && !config_restart) [*6];
  endsequence
  sequence reinit_burst;
    global_reinit_pulse [*4] ##1 !global_reinit_pulse;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ==========================================================
  // wake sequencing
  a_suspend_locks: assert property ((!wake_status_pin_out && !config_restart) |-> !write_unlock && !output_release)
    else $error("unlock or release while suspended");
  a_crc_halted: assert property ((!wake_status_pin_out && !config_restart) |-> !crc_check_enable)
    else $error("crc checking runs during suspend");
  a_stall_low: assert property (pin_held_low |-> !$rose(output_release) && !$rose(write_unlock))
    else $error("release counter ran while wake pin held low");
  a_release_wake_status_pin: assert property (($rose(write_unlock) || $rose(output_release)) |-> wake_status_pin_out)
    else $error("release before wake pin high");
  a_reinit_quiet: assert property (global_reinit_pulse |-> !wake_status_pin_out && !write_unlock && !output_release)
    else $error("reinit pulse after wake pin or counters");
  a_reinit_len: assert property ($rose(global_reinit_pulse) |-> reinit_burst)
    else $error("reinit pulse length wrong");
  a_supply_restart: assert property (($fell(supply_core_ok && supply_aux_ok) && !wake_status_pin_out)
    |-> ##[1:8] config_restart)
    else $error("no restart after supply loss in suspend");
  // ==========================================================
  // register bus answers
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule
bind swu_sequencer swu_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .wake_status_pin_in(wake_status_pin_in), .supply_core_ok(supply_core_ok),
  .supply_aux_ok(supply_aux_ok), .wake_status_pin_out(wake_status_pin_out),
  .global_reinit_pulse(global_reinit_pulse), .write_unlock(write_unlock), .output_release(output_release),
  .crc_check_enable(crc_check_enable), .config_restart(config_restart));
`default_nettype wire

// ### sim/swu_partner.sv
// outside controller: suspend pin, shared wake wire with pull-up, user wake clock
`default_nettype none
module swu_partner (
  input wire logic aclk,
  input wire logic suspend_cmd,
  input wire logic hold_low,
  input wire logic clk_run,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic suspend_request_pin,
  output logic wake_wire,
  output logic user_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg; // half period of the user clock, 4 aclk
  // ==========================================================
  // wire resolution
  // pull-up wins unless a party sinks the wire; peers may hold it low
  assign wake_wire = hold_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  assign suspend_request_pin = suspend_cmd;
  // ==========================================================
  // user clock, 12.5 MHz, still when not running so a wrong source stalls
  initial begin
    div_reg = 2'h0;
    user_clock_pin = 1'b0;
  end
  always @(posedge aclk) begin
    if (clk_run) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) user_clock_pin <= ~user_clock_pin;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the wake sequencer
`include "swu_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, suspend_request_pin, wake_wire;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] wake_request_pins;
  logic user_clock_pin, supply_core_ok, supply_aux_ok, crc_error_event, wake_status_pin_out, wake_status_pin_oe;
  logic global_reinit_pulse, write_unlock, output_release, crc_check_enable, config_restart;
  logic sus_cmd, hold_low, clk_run, seen_reinit; // partner controls and reinit monitor
  int fails, checked, cyc, rc, uc, c;
  // per case: control word, counts, wake tick period in aclk cycles
  int ctl_t [3] = '{32'h01, 32'h07, 32'h09};
  int rel_t [3] = '{4, 1, 10};
  int unl_t [3] = '{5, 1, 20};
  int per_t [3] = '{8, 8, 2};
  swu_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .suspend_request_pin,
    .wake_status_pin_in(wake_wire), .wake_request_pins, .user_clock_pin, .supply_core_ok, .supply_aux_ok,
    .crc_error_event, .wake_status_pin_out, .wake_status_pin_oe, .global_reinit_pulse, .write_unlock,
    .output_release, .crc_check_enable, .config_restart);
  swu_partner u_partner (.aclk, .suspend_cmd(sus_cmd), .hold_low, .clk_run, .pin_out(wake_status_pin_out),
    .pin_oe(wake_status_pin_oe), .suspend_request_pin, .wake_wire, .user_clock_pin);
  // ==========================================================
  // clock, watchdog and reinit monitor
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (global_reinit_pulse === 1'b1) seen_reinit <= 1'b1;
    if (cyc == 40000) begin // a hang counts as a mismatch
      fails++;
      final_report;
    end
  end
  // ==========================================================
  // tasks
  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task axi_rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_request_pins} = '0;
    s_axi_wstrb = 4'hf;
    {supply_core_ok, supply_aux_ok, crc_error_event, sus_cmd, hold_low, clk_run} = 6'h31;
    {fails, checked, cyc} = '0;
    seen_reinit = 1'b0;
    tick(10);
    aresetn <= 1'b1;
    tick(5);
    axi_rd(`SWU_CTRL_OFS, 32'h0, `SWU_RESP_OKAY);
    axi_rd(`SWU_MASK_OFS, {24'h0, `SWU_MASK_RESET}, `SWU_RESP_OKAY);
    axi_rd(`SWU_UNLOCK_OFS, {21'h0, `SWU_UNLOCK_RESET}, `SWU_RESP_OKAY);
    axi_rd(`SWU_RELEASE_OFS, {21'h0, `SWU_RELEASE_RESET}, `SWU_RESP_OKAY);
    axi_rd(`SWU_STATUS_OFS, 32'h38, `SWU_RESP_OKAY);
    axi_rd(5'h14, 32'h0, `SWU_RESP_SLVERR);
    axi_wr(5'h18, 32'hffff_ffff, `SWU_RESP_SLVERR);
    axi_wr(`SWU_STATUS_OFS, 32'hff, `SWU_RESP_OKAY);
    axi_rd(`SWU_STATUS_OFS, 32'h38, `SWU_RESP_OKAY);
    axi_wr(`SWU_UNLOCK_OFS, 32'h0, `SWU_RESP_OKAY);
    axi_rd(`SWU_UNLOCK_OFS, 32'h1, `SWU_RESP_OKAY);
    axi_wr(`SWU_RELEASE_OFS, 32'h7ff, `SWU_RESP_OKAY);
    axi_rd(`SWU_RELEASE_OFS, 32'h400, `SWU_RESP_OKAY);
    // open drain with held pin, active drive with reinit, internal clock
    for (int i = 0; i < 3; i++) begin
      clk_run <= (i != 2);
      seen_reinit <= 1'b0;
      axi_wr(`SWU_CTRL_OFS, ctl_t[i], `SWU_RESP_OKAY);
      axi_wr(`SWU_RELEASE_OFS, rel_t[i], `SWU_RESP_OKAY);
      axi_wr(`SWU_UNLOCK_OFS, unl_t[i], `SWU_RESP_OKAY);
      sus_cmd <= 1'b1;
      while (wake_wire) @(posedge aclk);
      tick(2);
      chk(32'({wake_status_pin_oe, wake_status_pin_out, crc_check_enable, write_unlock, output_release}), 32'h10);
      wake_request_pins <= 8'hff;
      hold_low <= (i == 0);
      tick(40);
      chk(32'(wake_status_pin_out), 32'h0);
      wake_request_pins <= 8'h00;
      sus_cmd <= 1'b0;
      if (i == 0) begin
        tick(100);
        chk(32'({write_unlock, output_release}), 32'h0);
        chk(32'({wake_status_pin_out, wake_status_pin_oe}), 32'h2);
        hold_low <= 1'b0;
      end
      while (!wake_wire) @(posedge aclk);
      {rc, uc, c} = '0;
      while (!(output_release && write_unlock)) begin
        @(posedge aclk);
        c++;
        if (output_release && rc == 0) rc = c;
        if (write_unlock && uc == 0) uc = c;
      end
      chk(32'(rc > per_t[i] * (rel_t[i] - 1) && rc <= per_t[i] * rel_t[i] + 6), 32'h1);
      chk(32'(uc > per_t[i] * (unl_t[i] - 1) && uc <= per_t[i] * unl_t[i] + 6), 32'h1);
      chk(32'(seen_reinit), 32'(i == 1));
      chk(32'({wake_status_pin_out, wake_status_pin_oe}), (i == 1) ? 32'h3 : 32'h2);
    end
    // multi-pin wake through the mask
    clk_run <= 1'b1;
    axi_wr(`SWU_MASK_OFS, 32'h0f, `SWU_RESP_OKAY);
    axi_wr(`SWU_CTRL_OFS, 32'h11, `SWU_RESP_OKAY);
    sus_cmd <= 1'b1;
    while (wake_wire) @(posedge aclk);
    wake_request_pins <= 8'hf0;
    tick(40);
    chk(32'(wake_status_pin_out), 32'h0);
    wake_request_pins <= 8'h08;
    tick(20);
    chk(32'(wake_status_pin_out), 32'h1);
    wake_request_pins <= 8'h00;
    sus_cmd <= 1'b0;
    while (!(output_release && write_unlock)) @(posedge aclk);
    // crc error then suspend: controller misuse on purpose
    axi_wr(`SWU_CTRL_OFS, 32'h21, `SWU_RESP_OKAY);
    tick(5);
    chk(32'(crc_check_enable), 32'h1);
    crc_error_event <= 1'b1;
    tick(4);
    crc_error_event <= 1'b0;
    sus_cmd <= 1'b1;
    while (wake_wire) @(posedge aclk);
    sus_cmd <= 1'b0;
    tick(200);
    chk(32'(wake_status_pin_out), 32'h0);
    axi_rd(`SWU_STATUS_OFS, 32'h41, `SWU_RESP_OKAY);
    supply_core_ok <= 1'b0;
    tick(10);
    chk(32'(config_restart), 32'h1);
    supply_core_ok <= 1'b1;
    while (!(output_release && write_unlock)) @(posedge aclk);
    tick(5);
    axi_rd(`SWU_STATUS_OFS, 32'h38, `SWU_RESP_OKAY);
    final_report;
  end
endmodule
`default_nettype wire
